// file: hw/iof_pkg.sv
/*
 * Shared constants and types of the I/O expander with fan control:
 * register offsets, reset values, field positions, bus addresses and timing.
 * Assumes a single 125 MHz system clock in every module that imports it.
 */
package iof_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned FAN_KICK_INTERVAL_MS = 1000;
    localparam int unsigned FAN_KICK_CYCLES = CLK_HZ / 1000 * FAN_KICK_INTERVAL_MS;
    localparam int unsigned FAN_KICK_CNT_W = 27;

    localparam logic [7:0] REG_DEVICE_CONFIG = 8'h00;
    localparam logic [7:0] REG_PIN_DIRECTION = 8'h01;
    localparam logic [7:0] REG_DRIVE_TYPE = 8'h02;
    localparam logic [7:0] REG_CHANGE_FLAGS = 8'h03;
    localparam logic [7:0] REG_PIN_IRQ_ENABLE = 8'h04;
    localparam logic [7:0] REG_PIN_VALUE = 8'h05;
    localparam logic [7:0] REG_FAN_LEVEL = 8'h06;

    localparam logic [7:0] DEVICE_CONFIG_RST = 8'h00;
    localparam logic [7:0] PIN_DIRECTION_RST = 8'h00;
    localparam logic [7:0] DRIVE_TYPE_RST = 8'h00;
    localparam logic [7:0] CHANGE_FLAGS_RST = 8'h00;
    localparam logic [7:0] PIN_IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] PIN_VALUE_RST = 8'hFF;
    localparam logic [7:0] FAN_LEVEL_RST = 8'h00;

    localparam int unsigned CFG_IRQ_EN_BIT = 0;
    localparam int unsigned CFG_FAN_MODE_BIT = 1;
    localparam logic [7:0] CFG_KEEP_MASK = 8'h03;
    localparam logic [7:0] FAN_KEEP_MASK = 8'h07;
    localparam logic [7:0] FAN_PIN_MASK = 8'hF0;
    localparam logic [2:0] FAN_LEVEL_OFF = 3'h0;
    localparam logic [2:0] FAN_LEVEL_FASTEST = 3'h7;

    localparam logic [6:0] SMB_ADDR_BASE = 7'h20;
    localparam logic [6:0] SMB_ALERT_RESP_ADDR = 7'h0C;
    localparam logic [3:0] SMB_BYTE_BITS = 4'h8;
    localparam logic [3:0] SMB_LAST_TX_BIT = 4'h7;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef struct packed {
        logic [7:0] device_config;
        logic [7:0] pin_direction;
        logic [7:0] drive_type;
        logic [7:0] change_flags;
        logic [7:0] pin_irq_enable;
        logic [7:0] pin_value;
        logic [7:0] fan_level;
    } iof_regs_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } iof_access_type;

endpackage

// file: hw/iof_sync.sv
/*
 * Two-flop synchroniser for a vector of slow external levels.
 * Assumes each bit changes far slower than the clock; bits are not coherent.
 */
`timescale 1ns/1ps
module iof_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] stable_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= d_i;
            stable_r <= meta_r;
        end
    end

    assign q_o = stable_r;
endmodule

// file: hw/iof_kick.sv
/*
 * Fan start-up kick timer and fan output encoder.
 * Assumes load_i pulses for one cycle when the level goes from off to on.
 */
`timescale 1ns/1ps
module iof_kick
    import iof_pkg::*;
#(
    parameter int unsigned KICK_CYCLES = FAN_KICK_CYCLES,
    parameter int CNT_W = FAN_KICK_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [2:0] level_i,
    output logic [2:0] level_n_o,
    output logic off_n_o
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [2:0] level_eff;

    if (KICK_CYCLES < 1 || KICK_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_kick
        $error("iof_kick: KICK_CYCLES does not fit the counter");
    end

    always_comb begin
        count_nxt = count_r;
        if (load_i) begin
            count_nxt = CNT_W'(KICK_CYCLES);
        end else if (count_r != '0) begin
            count_nxt = count_r - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // A write of zero during the kick stops the fan at once rather than finishing the kick.
    assign level_eff = (count_r != '0 && level_i != FAN_LEVEL_OFF) ? FAN_LEVEL_FASTEST : level_i;
    assign level_n_o = ~level_eff;
    assign off_n_o = (level_eff != FAN_LEVEL_OFF);
endmodule

// file: hw/iof_top.sv
/*
 * Register bank, serial management slave and pin logic of an eight-pin I/O
 * expander with fan level mode. Assumes the bus wire levels are resolved
 * outside from the output enables, and that all pins are asynchronous.
 */
// What this block does
// - Global interrupt enable bit gates all pin-change attention; resets disabled.
// - Fan mode bit hands upper four pins to fan outputs; otherwise all general I/O.
// - Direction bit one makes an output, zero an input; all inputs after reset.
// - In fan mode upper pins are open-drain outputs, ignoring direction and drive bits.
// - Drive type bit one is push-pull, zero open-drain; reset is open-drain.
// - Any input pin level change sets its change flag, interrupts enabled or not.
// - Reading the change flag register returns flags, then clears all of them.
// - Per-pin interrupt enable lets an input pin raise attention when set.
// - In fan mode the four fan pins raise no interrupt of any kind.
// - Pin value reads give live input levels and last written output values.
// - Pin value writes change output pins only; input bits are discarded.
// - In fan mode upper pin value bits do not reach the pins.
// - Fan outputs are the inverse level field; off output low only at zero.
// - Off-to-on level writes give fastest setting about one second first.
// - Attention asserts on a change only with global, pin enable and input.
// - Attention releases after alert response address answer or flag register read.
// - Registers use byte read and byte write; command byte is register address.
`timescale 1ns/1ps
module iof_top
    import iof_pkg::*;
#(
    parameter int unsigned KICK_CYCLES = FAN_KICK_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SMB_CLK_I,
    input wire logic SMB_DATA_I,
    output logic SMB_DATA_O,
    output logic SMB_DATA_OE_O,
    input wire logic [2:0] ADDR_SEL_I,
    input wire logic [7:0] IO_PIN_I,
    output logic [7:0] IO_PIN_O,
    output logic [7:0] IO_PIN_OE_O,
    output logic ALERT_N_O,
    output logic ALERT_N_OE_O
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
    } iof_state_type;

    typedef enum logic [1:0] {KIND_WRITE, KIND_READ, KIND_ARA} iof_kind_type;

    logic [12:0] sync_q;
    logic scl_q;
    logic sda_q;
    logic [2:0] strap_q;
    logic [7:0] pin_q;

    iof_sync #(.W(13)) u_sync (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .d_i({SMB_CLK_I, SMB_DATA_I, ADDR_SEL_I, IO_PIN_I}),
        .q_o(sync_q)
    );

    assign scl_q = sync_q[12];
    assign sda_q = sync_q[11];
    assign strap_q = sync_q[10:8];
    assign pin_q = sync_q[7:0];

    // Edge and condition detection on the synchronised bus wires.
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise = scl_q & ~scl_d_r;
    assign scl_fall = ~scl_q & scl_d_r;
    assign bus_start = scl_q & scl_d_r & sda_d_r & ~sda_q;
    assign bus_stop = scl_q & scl_d_r & ~sda_d_r & sda_q;

    // Address strap, caught once after the synchroniser has settled.
    logic [1:0] strap_cnt_r;
    logic [1:0] strap_cnt_nxt;
    logic strap_done_r;
    logic strap_done_nxt;
    logic [6:0] own_addr_r;
    logic [6:0] own_addr_nxt;
    logic [7:0] pin_prev_r;
    logic [7:0] pin_prev_nxt;

    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        strap_done_nxt = strap_done_r;
        own_addr_nxt = own_addr_r;
        pin_prev_nxt = pin_q;
        if (!strap_done_r) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
            if (strap_cnt_r == STRAP_SETTLE) begin
                strap_done_nxt = 1'b1;
                own_addr_nxt = {SMB_ADDR_BASE[6:3], strap_q};
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            own_addr_r <= SMB_ADDR_BASE;
            pin_prev_r <= 8'h00;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            strap_done_r <= strap_done_nxt;
            own_addr_r <= own_addr_nxt;
            pin_prev_r <= pin_prev_nxt;
            scl_d_r <= scl_q;
            sda_d_r <= sda_q;
        end
    end

    // Register bank state.
    iof_regs_type regs_r;
    iof_regs_type regs_nxt;
    logic alert_r;
    logic alert_nxt;
    logic kick_load;
    iof_access_type acc;
    logic ara_done;

    logic fan_mode;
    logic irq_en;
    logic [7:0] fan_pins;
    logic [7:0] out_mask;
    logic [7:0] in_mask;
    logic [7:0] change_set;
    logic flag_clear;

    assign fan_mode = regs_r.device_config[CFG_FAN_MODE_BIT];
    assign irq_en = regs_r.device_config[CFG_IRQ_EN_BIT];
    assign fan_pins = fan_mode ? FAN_PIN_MASK : 8'h00;
    assign out_mask = regs_r.pin_direction & ~fan_pins;
    assign in_mask = ~regs_r.pin_direction & ~fan_pins;
    // Flags stay quiet until the synchroniser holds real pin levels.
    assign change_set = strap_done_r ? ((pin_q ^ pin_prev_r) & in_mask) : 8'h00;
    assign flag_clear = acc.rd && (acc.addr == REG_CHANGE_FLAGS);

    function automatic logic [7:0] read_reg(input logic [7:0] addr, input iof_regs_type r,
                                            input logic [7:0] live, input logic [7:0] omask);
        case (addr)
            REG_DEVICE_CONFIG: read_reg = r.device_config;
            REG_PIN_DIRECTION: read_reg = r.pin_direction;
            REG_DRIVE_TYPE: read_reg = r.drive_type;
            REG_CHANGE_FLAGS: read_reg = r.change_flags;
            REG_PIN_IRQ_ENABLE: read_reg = r.pin_irq_enable;
            REG_PIN_VALUE: read_reg = (r.pin_value & omask) | (live & ~omask);
            REG_FAN_LEVEL: read_reg = r.fan_level;
            default: read_reg = 8'h00;
        endcase
    endfunction

    always_comb begin
        regs_nxt = regs_r;
        kick_load = 1'b0;
        if (acc.wr) begin
            case (acc.addr)
                REG_DEVICE_CONFIG: regs_nxt.device_config = acc.data & CFG_KEEP_MASK;
                REG_PIN_DIRECTION: regs_nxt.pin_direction = acc.data;
                REG_DRIVE_TYPE: regs_nxt.drive_type = acc.data;
                REG_PIN_IRQ_ENABLE: regs_nxt.pin_irq_enable = acc.data;
                REG_PIN_VALUE: begin
                    regs_nxt.pin_value = (regs_r.pin_value & ~out_mask) | (acc.data & out_mask);
                end
                REG_FAN_LEVEL: begin
                    regs_nxt.fan_level = acc.data & FAN_KEEP_MASK;
                    kick_load = (regs_r.fan_level[2:0] == FAN_LEVEL_OFF) &&
                                (acc.data[2:0] != FAN_LEVEL_OFF);
                end
                default: regs_nxt.fan_level = regs_r.fan_level;
            endcase
        end
        // A change in the cycle of the clearing read survives it.
        regs_nxt.change_flags = (flag_clear ? 8'h00 : regs_r.change_flags) | change_set;
        alert_nxt = (irq_en && ((change_set & regs_r.pin_irq_enable) != 8'h00)) ||
                    (alert_r && !flag_clear && !ara_done);
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            regs_r <= '{DEVICE_CONFIG_RST, PIN_DIRECTION_RST, DRIVE_TYPE_RST, CHANGE_FLAGS_RST,
                        PIN_IRQ_ENABLE_RST, PIN_VALUE_RST, FAN_LEVEL_RST};
            alert_r <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
            alert_r <= alert_nxt;
        end
    end

    // Serial management slave: byte write, byte read with repeated start, alert response.
    iof_state_type state_r;
    iof_state_type state_nxt;
    iof_kind_type kind_r;
    iof_kind_type kind_nxt;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] cmd_r;
    logic [7:0] cmd_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic rx_state;
    logic rx_done;
    logic [7:0] tx_byte;

    assign rx_state = (state_r == ST_ADDR) || (state_r == ST_CMD) || (state_r == ST_WDATA);
    assign rx_done = rx_state && scl_fall && (bit_cnt_r == SMB_BYTE_BITS);
    assign tx_byte = (kind_r == KIND_ARA) ? {own_addr_r, 1'b0} :
                     read_reg(cmd_r, regs_r, pin_q, out_mask);

    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        sda_oe_nxt = sda_oe_r;
        acc = '0;
        ara_done = 1'b0;
        if (rx_state && scl_rise && bit_cnt_r != SMB_BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_q};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        if (rx_done) begin
            bit_cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b1;
        end
        if (bus_stop) begin
            state_nxt = ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (bus_start) begin
            state_nxt = ST_ADDR;
            bit_cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_ADDR: begin
                    if (rx_done) begin
                        state_nxt = ST_ADDR_ACK;
                        if (shift_r[7:1] == own_addr_r) begin
                            kind_nxt = shift_r[0] ? KIND_READ : KIND_WRITE;
                        end else if (shift_r[7:1] == SMB_ALERT_RESP_ADDR && shift_r[0] && alert_r) begin
                            kind_nxt = KIND_ARA;
                        end else begin
                            state_nxt = ST_IGNORE;
                            sda_oe_nxt = 1'b0;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (kind_r == KIND_WRITE) begin
                            state_nxt = ST_CMD;
                            sda_oe_nxt = 1'b0;
                        end else begin
                            state_nxt = ST_TX;
                            shift_nxt = tx_byte;
                            sda_oe_nxt = ~tx_byte[7];
                            acc.rd = (kind_r == KIND_READ);
                            acc.addr = cmd_r;
                        end
                    end
                end
                ST_CMD: begin
                    if (rx_done) begin
                        cmd_nxt = shift_r;
                        state_nxt = ST_CMD_ACK;
                    end
                end
                ST_CMD_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_nxt = (state_r == ST_CMD_ACK) ? ST_WDATA : ST_IGNORE;
                        sda_oe_nxt = 1'b0;
                    end
                end
                ST_WDATA: begin
                    if (rx_done) begin
                        acc.wr = 1'b1;
                        acc.addr = cmd_r;
                        acc.data = shift_r;
                        state_nxt = ST_WDATA_ACK;
                    end
                end
                ST_TX: begin
                    // Open-drain sending: a one read back as zero means another responder won.
                    if (scl_rise && shift_r[7] && !sda_q) begin
                        state_nxt = ST_IGNORE;
                        sda_oe_nxt = 1'b0;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == SMB_LAST_TX_BIT) begin
                            state_nxt = ST_TX_ACK;
                            sda_oe_nxt = 1'b0;
                            ara_done = (kind_r == KIND_ARA);
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            sda_oe_nxt = ~shift_r[6];
                            bit_cnt_nxt = bit_cnt_r + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        state_nxt = ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE: state_nxt = state_r;
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_r <= ST_IDLE;
            kind_r <= KIND_WRITE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            sda_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    // Pin drivers.
    logic [2:0] fan_level_out_n;
    logic fan_off_n;
    logic [3:0] fan_drive;
    logic [7:0] pin_o_r;
    logic [7:0] pin_o_nxt;
    logic [7:0] pin_oe_r;
    logic [7:0] pin_oe_nxt;

    iof_kick #(.KICK_CYCLES(KICK_CYCLES), .CNT_W(FAN_KICK_CNT_W)) u_kick (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .load_i(kick_load),
        .level_i(regs_r.fan_level[2:0]),
        .level_n_o(fan_level_out_n),
        .off_n_o(fan_off_n)
    );

    assign fan_drive = {fan_level_out_n, fan_off_n};

    always_comb begin
        pin_o_nxt = 8'h00;
        pin_oe_nxt = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (fan_pins[i]) begin
                pin_oe_nxt[i] = ~fan_drive[2'(i)];
            end else if (regs_r.pin_direction[i]) begin
                if (regs_r.drive_type[i]) begin
                    pin_o_nxt[i] = regs_r.pin_value[i];
                    pin_oe_nxt[i] = 1'b1;
                end else begin
                    pin_oe_nxt[i] = ~regs_r.pin_value[i];
                end
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pin_o_r <= 8'h00;
            pin_oe_r <= 8'h00;
        end else begin
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign IO_PIN_O = pin_o_r;
    assign IO_PIN_OE_O = pin_oe_r;
    assign SMB_DATA_O = 1'b0;
    assign SMB_DATA_OE_O = sda_oe_r;
    assign ALERT_N_O = 1'b0;
    assign ALERT_N_OE_O = alert_r;
endmodule

// file: dv/iof_top_asserts.sv
/* Port checker for the I/O expander top.
   Assumes it is bound to iof_top and sees only its ports. */
`timescale 1ns/1ps
module iof_top_asserts (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SMB_CLK_I,
    input wire logic SMB_DATA_O,
    input wire logic SMB_DATA_OE_O,
    input wire logic [7:0] IO_PIN_I,
    input wire logic [7:0] IO_PIN_OE_O,
    input wire logic ALERT_N_O,
    input wire logic ALERT_N_OE_O
);
    logic clk_d_r;
    logic [4:0] idle_r;
    // Counts cycles since the bus clock last moved, saturating so it never wraps.
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            clk_d_r <= 1'b1;
            idle_r <= 5'h00;
        end else begin
            clk_d_r <= SMB_CLK_I;
            idle_r <= (SMB_CLK_I != clk_d_r) ? 5'h00 : idle_r + {4'h0, idle_r != 5'h1F};
        end
    end
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);
    AST_SDA_CHG: assert property (
        $changed(SMB_DATA_OE_O) |-> !SMB_CLK_I && !$past(SMB_CLK_I, 2))
        else $error("data drive moved outside clock low");
    AST_ALERT_CAUSE: assert property (
        $rose(ALERT_N_OE_O) |-> $past(IO_PIN_I, 3) != $past(IO_PIN_I, 6))
        else $error("attention without a pin change");
    AST_ALERT_HOLD: assert property (
        (ALERT_N_OE_O && SMB_CLK_I) [*8] |=> ALERT_N_OE_O)
        else $error("attention dropped on a quiet bus");
    AST_ALERT_REL: assert property (
        $fell(ALERT_N_OE_O) |-> !SMB_CLK_I && idle_r > 5'h01)
        else $error("attention released off a clock fall");
    AST_LOW_OE_BUS: assert property (
        $changed(IO_PIN_OE_O[3:0]) |-> $past(SMB_CLK_I, 5) && !$past(SMB_CLK_I, 4))
        else $error("lower pin drive moved without a write");
    AST_OE_SETTLE: assert property (
        $changed(IO_PIN_OE_O[3:0]) |=> $stable(IO_PIN_OE_O[3:0]) [*4])
        else $error("lower pin drive glitched");
    AST_KICK_END: assert property (
        $changed(IO_PIN_OE_O[7:5]) && idle_r > 5'h10
        |-> $past(IO_PIN_OE_O[7:4]) == 4'hE && !IO_PIN_OE_O[4])
        else $error("fan pins moved outside a kick end");
    AST_OPEN_DRAIN: assert property (!SMB_DATA_O && !ALERT_N_O)
        else $error("open-drain output driven high");
endmodule
bind iof_top iof_top_asserts chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .SMB_CLK_I(SMB_CLK_I),
    .SMB_DATA_O(SMB_DATA_O), .SMB_DATA_OE_O(SMB_DATA_OE_O), .IO_PIN_I(IO_PIN_I),
    .IO_PIN_OE_O(IO_PIN_OE_O), .ALERT_N_O(ALERT_N_O), .ALERT_N_OE_O(ALERT_N_OE_O));

// file: dv/iof_host.sv
/* Bus host model giving byte writes, byte reads and alert polls.
   Assumes the bench resolves the pulled-up data wire from both enables. */
`timescale 1ns/1ps
module iof_host
    import iof_pkg::*;
(
    input wire logic clk_i,
    input wire logic sda_i,
    input wire logic [6:0] dev_i,
    output logic scl_o,
    output logic sda_oe_o
);
    int nacks = 0;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // A bit lasts 8 cycles, 64 ns; each phase still outlasts the device's two-flop sampling.
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_oe_o <= ~b;
        w(2);
        scl_o <= 1'b1;
        w(4);
        r = sda_i;
        scl_o <= 1'b0;
        w(2);
    endtask
    task automatic start();
        sda_oe_o <= 1'b0;
        w(2);
        scl_o <= 1'b1;
        w(2);
        sda_oe_o <= 1'b1;
        w(2);
        scl_o <= 1'b0;
        w(2);
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        w(2);
        scl_o <= 1'b1;
        w(2);
        sda_oe_o <= 1'b0;
        w(8);
    endtask
    task automatic bytex(input logic [7:0] d, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, a);
        nacks += (d == 8'hFF) ? 0 : int'(a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        start();
        bytex({dev_i, 1'b0}, q);
        bytex(a, q);
        bytex(d, q);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        start();
        bytex({dev_i, 1'b0}, q);
        bytex(a, q);
        start();
        bytex({dev_i, 1'b1}, q);
        bytex(8'hFF, q);
        stop();
    endtask
    task automatic ara(output logic [7:0] q);
        start();
        bytex({SMB_ALERT_RESP_ADDR, 1'b1}, q);
        bytex(8'hFF, q);
        stop();
    endtask
endmodule

// file: dv/iof_top_test.sv
/* Self-checking bench for the I/O expander top against a register model.
   Assumes pulled-up pins and data wire resolved here from all enables. */
`timescale 1ns/1ps
module iof_top_test
    import iof_pkg::*;
;
    localparam int KC = 2000;
    logic clk = 1'b0, rst = 1'b1, sda_dev, alert_oe, scl, sda_oe;
    logic [7:0] io_o, io_oe, q, ext = 8'hFF;
    logic [2:0] sel;
    int seed = 6689, miscompares = 0, total_checks = 0;
    int m[8] = '{0, 0, 0, 0, 0, 255, 0, 0};
    wire [7:0] pins = (io_oe & io_o) | (~io_oe & ext);
    wire sda = ~(sda_oe | sda_dev);
    wire [6:0] dev = SMB_ADDR_BASE | {4'h0, sel};
    always #4 clk = ~clk;
    iof_top #(.KICK_CYCLES(KC)) uut (.CLK_I(clk), .RESET_I(rst), .SMB_CLK_I(scl),
        .SMB_DATA_I(sda), .SMB_DATA_O(), .SMB_DATA_OE_O(sda_dev), .ADDR_SEL_I(sel),
        .IO_PIN_I(pins), .IO_PIN_O(io_o), .IO_PIN_OE_O(io_oe), .ALERT_N_O(),
        .ALERT_N_OE_O(alert_oe));
    iof_host h (.clk_i(clk), .sda_i(sda), .dev_i(dev), .scl_o(scl), .sda_oe_o(sda_oe));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rr(input int a);
        logic [7:0] e;
        e = (a == 5) ? 8'((m[1] & m[5]) | (~m[1] & ext)) : 8'(m[a]);
        h.rd(8'(a), q);
        chk("register", q, e);
        if (a == 3) m[3] = 0;
    endtask
    task automatic wm(input int a, input int d);
        h.wr(8'(a), 8'(d));
        if (a == 5) m[5] = (m[1] & d) | (~m[1] & m[5]);
        else if (a != 3) m[a] = d & ((a == 0) ? 3 : (a == 6) ? 7 : 255);
    endtask
    initial begin
        logic [7:0] f;
        logic [2:0] l;
        sel = 3'($random(seed));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        for (int a = 0; a < 8; a++) rr(a);
        $display("reset values done");
        // Pin 0 stays an input so every flag round has a certain event.
        for (int a = 0; a < 7; a++) begin
            wm(a, $random(seed) & ((a == 0) ? 1 : (a == 6) ? 7 : (a == 1) ? 254 : 255));
            rr(a);
        end
        chk("drive", io_oe, 8'(m[1] & (m[2] | ~m[5])));
        chk("level", io_oe & io_o, 8'(m[1] & m[2] & m[5]));
        $display("register and pin test done");
        for (int r = 0; r < 3; r++) begin
            wm(0, r != 0);
            wm(4, $random(seed) | 1);
            f = 8'($random(seed)) | 8'h01;
            @(posedge clk);
            ext <= ext ^ f;
            repeat (8) @(posedge clk);
            m[3] |= f & ~m[1];
            chk("alert", {7'h0, alert_oe}, 8'(r != 0));
            if (r == 2) begin
                h.ara(q);
                chk("ara", q, {dev, 1'b0});
            end else begin
                rr(3);
            end
            chk("alert", {7'h0, alert_oe}, 8'h00);
            rr(3);
        end
        $display("change flag test done");
        wm(6, 0);
        wm(0, 3);
        chk("fan off", {4'h0, io_oe[7:4]}, 8'h01);
        l = 3'($random(seed) & 3) | 3'h1;
        wm(6, l);
        chk("kick", {4'h0, io_oe[7:4]}, 8'h0E);
        @(posedge clk);
        ext <= ext ^ 8'hF0;
        repeat (KC) @(posedge clk);
        chk("fan level", {4'h0, io_oe[7:4]}, {4'h0, l, 1'b0});
        wm(5, m[5] ^ 8'hF0);
        chk("fan level", {4'h0, io_oe[7:4]}, {4'h0, l, 1'b0});
        rr(3);
        wm(6, 0);
        chk("fan off", {4'h0, io_oe[7:4]}, 8'h01);
        chk("nacks", 8'(h.nacks), 8'h00);
        $display("fan test done");
        conclude();
    end
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
